//--- bench/test_usart_host_port_and_status.sv
// testbench of the usart host port and status block
`timescale 1ns/100ps
module test_usart_host_port_and_status
  import uhp_pkg::*;
;
  logic       clock, rst_b, master_reset, ce_n, wr, ext_tick, rx_in;
  logic [2:0] sel;
  logic [7:0] din, dout, rx_data, txh, m1, m2, cmd, sy1, sy2, esc, d, d2;
  logic       oe, rx_oe, rx_o, tx_oe, tx_o, em_oe, em_o, rx_vld, taken;
  logic       done, txf, mark, tick;
  logic [6:0] modem_n;
  logic       rx_pin, tx_pin, em_pin;
  int         failures, checks, tick_count, i;

  // open-drain request lines with pull-ups
  assign rx_pin = rx_oe ? rx_o : 1'h1;
  assign tx_pin = tx_oe ? tx_o : 1'h1;
  assign em_pin = em_oe ? em_o : 1'h1;

  uhp_cpu_model uhp_cpu_model_i (.clock(clock), .chip_enable_n(ce_n),
    .write_dir(wr), .register_select(sel), .host_data_bus_in(din),
    .host_data_bus_out(dout), .host_data_bus_oe(oe));

  uhp_host_port #(.RATE_TABLE({16{13'h0004}})) uhp_host_port_i (
    .clock(clock), .rst_b(rst_b), .master_reset(master_reset),
    .chip_enable_n(ce_n), .write_dir(wr), .register_select(sel),
    .host_data_bus_in(din), .host_data_bus_out(dout),
    .host_data_bus_oe(oe), .rx_char_ready_n_out(rx_o),
    .rx_char_ready_n_oe(rx_oe), .tx_holding_free_n_out(tx_o),
    .tx_holding_free_n_oe(tx_oe), .tx_empty_or_line_change_n_out(em_o),
    .tx_empty_or_line_change_n_oe(em_oe),
    .incoming_call_in(modem_n[M_CALL]), .test_mode_in(modem_n[M_TEST]),
    .signal_quality_in(modem_n[M_QUAL]),
    .standby_indicator_in(modem_n[M_STBY]),
    .signalling_rate_in(modem_n[M_RATE]), .data_mode_in(modem_n[M_DMODE]),
    .line_ready_in(modem_n[M_READY]), .rx_serial_in(rx_in),
    .rx_line_mark(mark), .rx_char_valid(rx_vld), .rx_char_data(rx_data),
    .tx_char_taken(taken), .tx_shift_done(done), .tx_holding_reg(txh),
    .tx_holding_full(txf), .mode_first(m1), .mode_second(m2),
    .command(cmd), .sync_char_first(sy1), .sync_char_second(sy2),
    .escape_char(esc), .ext_rate_tick(ext_tick), .rate_tick(tick));

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) if (tick === 1'h1) tick_count++;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic rd(input logic [2:0] s, input logic [7:0] exp,
                    input string what);
    logic [7:0] v;
    logic       ok;
    uhp_cpu_model_i.read_reg(s, v, ok);
    check({what, " answer"}, 8'h01, {7'h00, ok});
    check(what, exp, v);
  endtask

  task automatic wr_reg(input logic [2:0] s, input logic [7:0] v);
    uhp_cpu_model_i.write_reg(s, v);
    @(negedge clock);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  function automatic logic [7:0] pins();
    return {5'h00, em_pin, tx_pin, rx_pin};
  endfunction

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_b, master_reset, ext_tick, rx_vld, taken, done} = 6'h00;
    rx_data = 8'h00;
    rx_in = 1'h1;
    modem_n = 7'h7F;
    failures = 0;
    checks = 0;
    tick_count = 0;
    void'($urandom(32'h67A14C17));
    wait_n(6);
    rst_b = 1'h1;
    wait_n(2);
    check("reset command", REG_RESET, cmd);
    check("reset pins", 8'h07, pins());
    check("idle bus drive", 8'h00, {7'h00, oe});
    // configuration registers
    for (i = 1; i < 8; i++) begin
      if (i == 4 || i == 5) continue;
      d = 8'($urandom());
      wr_reg(3'(i), d);
      case (i)
        1: check("first sync", d, sy1);
        2: check("mode first", d, m1);
        3: check("mode second", d, m2);
        6: check("second sync", d, sy2);
        default: check("escape", d, esc);
      endcase
      if (i != 1) rd(3'(i), d, "readback");
    end
    wr_reg(ADDR_CMD, 8'h05);
    rd(ADDR_CMD, 8'h05, "command readback");
    wr_reg(ADDR_MODE2, 8'h00);
    // transmit side
    check("tx free pin", 8'h00, {7'h00, tx_pin});
    d = 8'($urandom());
    wr_reg(ADDR_HOLD, d);
    check("tx holding", d, txh);
    check("tx full", 8'h01, {7'h00, txf});
    check("tx loaded pin", 8'h01, {7'h00, tx_pin});
    taken = 1'h1;
    wait_n(1);
    taken = 1'h0;
    wait_n(1);
    check("tx taken pin", 8'h00, {7'h00, tx_pin});
    done = 1'h1;
    wait_n(1);
    done = 1'h0;
    wait_n(1);
    check("empty pin", 8'h00, {7'h00, em_pin});
    rd(ADDR_STAT1, 8'h05, "status one");
    check("empty kept", 8'h00, {7'h00, em_pin});
    wr_reg(ADDR_HOLD, d);
    check("empty released", 8'h01, {7'h00, em_pin});
    // receive side, second character while full is dropped
    d = 8'($urandom());
    d2 = ~d;
    rx_data = d;
    rx_vld = 1'h1;
    wait_n(1);
    rx_data = d2;
    wait_n(1);
    rx_vld = 1'h0;
    wait_n(1);
    check("rx ready pin", 8'h00, {7'h00, rx_pin});
    rd(ADDR_HOLD, d, "rx holding");
    check("rx read pin", 8'h01, {7'h00, rx_pin});
    rx_vld = 1'h1;
    wait_n(1);
    rx_vld = 1'h0;
    wr_reg(ADDR_CMD, 8'h01);
    check("rx off pin", 8'h01, {7'h00, rx_pin});
    // modem status inputs, enables off then on
    wr_reg(ADDR_STAT2, 8'h00);
    for (i = 0; i < 5; i++) begin
      modem_n[i] = 1'h0;
      wait_n(5);
      rd(ADDR_STAT2, 8'(1 << i), "status two");
      check("masked change", 8'h01, {7'h00, em_pin});
      modem_n[i] = 1'h1;
      wait_n(5);
    end
    wr_reg(ADDR_STAT2, 8'hFF);
    rd(ADDR_STAT2, 8'hE0, "enables");
    for (i = 0; i < 5; i++) begin
      modem_n[i] = 1'h0;
      wait_n(5);
      check("change pin", 8'h00, {7'h00, em_pin});
      rd(ADDR_STAT1, 8'h04, "change status");
      wait_n(5);
      check("single change", 8'h01, {7'h00, em_pin});
      modem_n[i] = 1'h1;
      wait_n(5);
      check("rise change", 8'h00, {7'h00, em_pin});
      rd(ADDR_STAT1, 8'h04, "rise status");
    end
    modem_n[M_DMODE] = 1'h0;
    wait_n(5);
    check("mode change", 8'h00, {7'h00, em_pin});
    rd(ADDR_STAT1, 8'h84, "mode status");
    modem_n[M_DMODE] = 1'h1;
    wait_n(5);
    // serial line sense
    for (i = 0; i < 6; i++) begin
      rx_in = 1'($urandom());
      wait_n(2);
      check("line mark", {7'h00, rx_in}, {7'h00, mark});
    end
    // master reset in mid-run
    master_reset = 1'h1;
    #1;
    check("async clear", REG_RESET, cmd);
    check("async mode", REG_RESET, m1);
    wait_n(1);
    master_reset = 1'h0;
    wait_n(2);
    check("reset pins again", 8'h07, pins());
    check("reset tx full", 8'h00, {7'h00, txf});
    // external then internal rate
    tick_count = 0;
    repeat (3) begin
      ext_tick = 1'h1;
      wait_n(1);
      ext_tick = 1'h0;
      wait_n(2);
    end
    check("external ticks", 8'h03, 8'(tick_count));
    wr_reg(ADDR_MODE2, 8'h10);
    tick_count = 0;
    wait_n(40);
    check("internal ticks", 8'h01,
          {7'h00, tick_count >= 9 && tick_count <= 11});
    end_of_test();
  end
endmodule

//--- bench/uhp_cpu_model.sv
// processor model that runs cycles on the host register bus
`timescale 1ns/100ps
module uhp_cpu_model (
  input  wire logic       clock,
  output logic            chip_enable_n,
  output logic            write_dir,
  output logic [2:0]      register_select,
  output logic [7:0]      host_data_bus_in,
  input  wire logic [7:0] host_data_bus_out,
  input  wire logic       host_data_bus_oe
);
  initial begin
    chip_enable_n = 1'h1;
    write_dir = 1'h0;
    register_select = 3'h0;
    host_data_bus_in = 8'h5A;
  end

  // ------------------------------------------------------------
  // bus cycles: one access per select period, select high between
  // ------------------------------------------------------------
  task automatic write_reg(input logic [2:0] sel, input logic [7:0] data);
    @(negedge clock);
    chip_enable_n = 1'h0;
    write_dir = 1'h1;
    register_select = sel;
    host_data_bus_in = data;
    @(negedge clock);
    chip_enable_n = 1'h1;
    // released bus must not keep showing the last value
    host_data_bus_in = ~data;
  endtask

  task automatic read_reg(input logic [2:0] sel, output logic [7:0] data,
                          output logic ok);
    int n;
    @(negedge clock);
    chip_enable_n = 1'h0;
    write_dir = 1'h0;
    register_select = sel;
    host_data_bus_in = ~host_data_bus_in;
    ok = 1'h0;
    data = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clock);
      if (host_data_bus_oe === 1'h1) begin
        ok = 1'h1;
        data = host_data_bus_out;
      end
    end
    chip_enable_n = 1'h1;
  endtask
endmodule

//--- rtl/uhp_edge_sync.sv
// synchroniser and change detector for the modem status inputs
`timescale 1ns/100ps
module uhp_edge_sync
  import uhp_pkg::*;
#(
  parameter int W = MODEM_N
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level,
  output logic      [W-1:0] change
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] last;

  // inputs idle high, so reset to ones to avoid a false change
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '1;
      stage2 <= '1;
      last   <= '1;
    end else begin
      stage1 <= raw;    // RULE22
      stage2 <= stage1;
      last   <= stage2;
    end
  end

  assign level  = stage2;
  assign change = stage2 ^ last;  // RULE22

endmodule

//--- rtl/uhp_host_port.sv
// processor port, status registers and request outputs of the usart
`timescale 1ns/100ps
module uhp_host_port
  import uhp_pkg::*;
#(
  parameter logic [16*DIV_W-1:0] RATE_TABLE = BAUD_TABLE
) (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       master_reset,
  input  wire logic       chip_enable_n,
  input  wire logic       write_dir,
  input  wire logic [2:0] register_select,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe,
  output logic            rx_char_ready_n_out,
  output logic            rx_char_ready_n_oe,
  output logic            tx_holding_free_n_out,
  output logic            tx_holding_free_n_oe,
  output logic            tx_empty_or_line_change_n_out,
  output logic            tx_empty_or_line_change_n_oe,
  input  wire logic       incoming_call_in,
  input  wire logic       test_mode_in,
  input  wire logic       signal_quality_in,
  input  wire logic       standby_indicator_in,
  input  wire logic       signalling_rate_in,
  input  wire logic       data_mode_in,
  input  wire logic       line_ready_in,
  input  wire logic       rx_serial_in,
  output logic            rx_line_mark,
  input  wire logic       rx_char_valid,
  input  wire logic [7:0] rx_char_data,
  input  wire logic       tx_char_taken,
  input  wire logic       tx_shift_done,
  output logic [7:0]      tx_holding_reg,
  output logic            tx_holding_full,
  output logic [7:0]      mode_first,
  output logic [7:0]      mode_second,
  output logic [7:0]      command,
  output logic [7:0]      sync_char_first,
  output logic [7:0]      sync_char_second,
  output logic [7:0]      escape_char,
  input  wire logic       ext_rate_tick,
  output logic            rate_tick
);

  // ------------------------------------------------------------
  // reset and access decode
  // ------------------------------------------------------------
  logic arst_b;
  logic ce_last;
  logic access_start;
  logic rd_start;
  logic wr_start;
  logic rd_rhr;
  logic rd_stat1;
  logic wr_thr;

  assign arst_b = rst_b & ~master_reset;  // RULE14

  function automatic logic sel_is(input logic [2:0] sel,
                                  input logic [2:0] code);
    return sel == code;
  endfunction

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      ce_last <= 1'b0;
    end else begin
      ce_last <= ~chip_enable_n;
    end
  end

  // side effects happen once, on the first selected cycle
  assign access_start = ~chip_enable_n & ~ce_last;  // RULE1
  assign rd_start     = access_start & ~write_dir;  // RULE3
  assign wr_start     = access_start & write_dir;   // RULE3
  assign rd_rhr   = rd_start & sel_is(register_select, ADDR_HOLD);
  assign rd_stat1 = rd_start & sel_is(register_select, ADDR_STAT1);
  assign wr_thr   = wr_start & sel_is(register_select, ADDR_HOLD);

  // ------------------------------------------------------------
  // modem status inputs
  // ------------------------------------------------------------
  logic [MODEM_N-1:0] modem_raw;
  logic [MODEM_N-1:0] modem_level;
  logic [MODEM_N-1:0] modem_change;
  logic [MODEM_N-1:0] change_mask;
  logic [2:0]         change_enable;
  logic               change_event;

  assign modem_raw = {data_mode_in, line_ready_in, signalling_rate_in,
                      standby_indicator_in, signal_quality_in,
                      test_mode_in, incoming_call_in};

  uhp_edge_sync #(.W(MODEM_N)) u_modem_sync (
    .clock  (clock),
    .rst_b  (arst_b),
    .raw    (modem_raw),
    .level  (modem_level),
    .change (modem_change)
  );

  always_comb begin
    change_mask          = '0;
    change_mask[M_CALL]  = change_enable[0];  // RULE15
    change_mask[M_TEST]  = change_enable[1];  // RULE16
    change_mask[M_QUAL]  = change_enable[2];  // RULE17
    change_mask[M_STBY]  = change_enable[2];  // RULE23
    change_mask[M_RATE]  = change_enable[2];  // RULE23
    change_mask[M_READY] = command[CMD_TX_EN] | command[CMD_RX_EN];
    change_mask[M_DMODE] = command[CMD_TX_EN] | command[CMD_RX_EN];
  end

  assign change_event = |(modem_change & change_mask);  // RULE10 RULE11

  // ------------------------------------------------------------
  // control and character registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      mode_first       <= REG_RESET;  // RULE14
      mode_second      <= REG_RESET;
      command          <= REG_RESET;
      change_enable    <= '0;
      sync_char_first  <= REG_RESET;
      sync_char_second <= REG_RESET;
      escape_char      <= REG_RESET;
    end else if (wr_start) begin
      unique case (register_select)  // RULE5
        ADDR_STAT1: sync_char_first  <= host_data_bus_in;  // RULE19
        ADDR_MODE1: mode_first       <= host_data_bus_in;
        ADDR_MODE2: mode_second      <= host_data_bus_in;
        ADDR_CMD:   command          <= host_data_bus_in;
        ADDR_STAT2: change_enable    <= host_data_bus_in[7:S2_EN_LO];
        ADDR_SYNC_CHAR_SECOND:  sync_char_second <= host_data_bus_in;  // RULE19
        ADDR_ESC:   escape_char      <= host_data_bus_in;  // RULE19
        ADDR_HOLD:  ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive holding register
  // ------------------------------------------------------------
  logic rx_enabled;
  logic rx_take;
  logic rx_char_flag;
  logic [7:0] rx_holding_reg;

  assign rx_enabled = command[CMD_RX_EN];
  // a character arriving with the releasing read is still taken
  assign rx_take = rx_char_valid & rx_enabled & (~rx_char_flag | rd_rhr);

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      rx_char_flag   <= 1'b0;
      rx_holding_reg <= REG_RESET;
    end else if (rx_take) begin
      rx_holding_reg <= rx_char_data;  // RULE21
      rx_char_flag   <= 1'b1;
    end else if (rd_rhr || !rx_enabled) begin
      rx_char_flag   <= 1'b0;          // RULE7
    end
  end

  // ------------------------------------------------------------
  // transmit holding register and empty/change latch
  // ------------------------------------------------------------
  logic tx_free_flag;
  logic tx_empty_latched;
  logic change_latched;
  logic empty_or_change_flag;

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      tx_holding_reg  <= REG_RESET;
      tx_holding_full <= 1'b0;
    end else if (wr_thr) begin
      tx_holding_reg  <= host_data_bus_in;
      tx_holding_full <= 1'b1;  // RULE8
    end else if (tx_char_taken) begin
      tx_holding_full <= 1'b0;
    end
  end

  assign tx_free_flag = command[CMD_TX_EN] & ~tx_holding_full;  // RULE8

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      tx_empty_latched <= 1'b0;
    end else if (tx_shift_done) begin
      tx_empty_latched <= 1'b1;  // RULE10
    end else if (wr_thr) begin
      tx_empty_latched <= 1'b0;  // RULE12
    end
  end

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      change_latched <= 1'b0;
    end else if (change_event) begin
      change_latched <= 1'b1;  // RULE11
    end else if (wr_thr || (rd_stat1 && !tx_empty_latched)) begin
      change_latched <= 1'b0;  // RULE12
    end
  end

  assign empty_or_change_flag = tx_empty_latched | change_latched;

  // ------------------------------------------------------------
  // status registers and read path
  // ------------------------------------------------------------
  logic [7:0] primary_status;
  logic [7:0] line_status_and_enables;
  logic [7:0] read_mux;

  always_comb begin
    primary_status               = '0;
    primary_status[S1_TX_FREE]   = tx_free_flag;
    primary_status[S1_RX_CHAR]   = rx_char_flag;
    primary_status[S1_EMPTY_CHG] = empty_or_change_flag;
    primary_status[S1_LINE_RDY]  = ~modem_level[M_READY];
    primary_status[S1_DATA_MODE] = ~modem_level[M_DMODE];
  end

  // inverted inputs low, enables high  // RULE15 RULE16 RULE17 RULE23
  assign line_status_and_enables = {change_enable, ~modem_level[4:0]};

  always_comb begin
    unique case (register_select)  // RULE5
      ADDR_HOLD:  read_mux = rx_holding_reg;
      ADDR_STAT1: read_mux = primary_status;
      ADDR_MODE1: read_mux = mode_first;
      ADDR_MODE2: read_mux = mode_second;
      ADDR_CMD:   read_mux = command;
      ADDR_STAT2: read_mux = line_status_and_enables;
      ADDR_SYNC_CHAR_SECOND:  read_mux = sync_char_second;
      ADDR_ESC:   read_mux = escape_char;
    endcase
  end

  // data captured at the start so clears do not disturb it
  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      host_data_bus_out <= REG_RESET;
    end else if (rd_start) begin
      host_data_bus_out <= read_mux;  // RULE4
    end
  end

  // drive from the second selected read cycle, float otherwise
  assign host_data_bus_oe = ~chip_enable_n & ~write_dir & ce_last;  // RULE2

  // ------------------------------------------------------------
  // open-drain request outputs
  // ------------------------------------------------------------
  assign rx_char_ready_n_out           = 1'b0;  // RULE13
  assign tx_holding_free_n_out         = 1'b0;
  assign tx_empty_or_line_change_n_out = 1'b0;
  assign rx_char_ready_n_oe            = rx_char_flag;          // RULE6
  assign tx_holding_free_n_oe          = tx_free_flag;          // RULE8
  assign tx_empty_or_line_change_n_oe  = empty_or_change_flag;  // RULE10

  // ------------------------------------------------------------
  // serial line level and rate generator
  // ------------------------------------------------------------
  logic [DIV_W-1:0] rate_count;
  logic [DIV_W-1:0] rate_limit;
  logic             rate_internal;

  function automatic logic [DIV_W-1:0] divisor(input logic [3:0] pick);
    return RATE_TABLE[pick*DIV_W +: DIV_W];
  endfunction

  assign rate_internal = mode_second[MODE2_INT];
  assign rate_limit    = divisor(mode_second[3:0]) - DIV_W'(1);

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      rx_line_mark <= 1'b1;
    end else begin
      rx_line_mark <= rx_serial_in;  // RULE18
    end
  end

  always_ff @(posedge clock or negedge arst_b) begin
    if (!arst_b) begin
      rate_count <= '0;
      rate_tick  <= 1'b0;
    end else if (!rate_internal) begin
      rate_count <= '0;
      rate_tick  <= ext_rate_tick;  // RULE20
    end else if (rate_count >= rate_limit) begin
      rate_count <= '0;
      rate_tick  <= 1'b1;           // RULE20
    end else begin
      rate_count <= rate_count + DIV_W'(1);
      rate_tick  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_b);

  bus_float_a: assert property ( // RULE2
    chip_enable_n |-> !host_data_bus_oe)
    else $error("data bus driven while deselected");

  write_float_a: assert property ( // RULE3
    (!chip_enable_n && write_dir) |-> !host_data_bus_oe)
    else $error("data bus driven during a write");

  rx_ready_a: assert property ( // RULE6
    rx_take |=> rx_char_ready_n_oe && rx_holding_reg == $past(rx_char_data))
    else $error("receive ready not raised with new character");

  rx_release_a: assert property ( // RULE7
    (rd_rhr && !rx_take) || !rx_enabled |=> !rx_char_ready_n_oe)
    else $error("receive ready not released");

  tx_load_a: assert property ( // RULE8
    wr_thr |=> !tx_holding_free_n_oe ##0 tx_holding_full)
    else $error("transmit ready still low after load");

  empty_set_a: assert property ( // RULE10
    tx_shift_done |=> tx_empty_or_line_change_n_oe)
    else $error("empty request not raised");

  call_change_a: assert property ( // RULE11 RULE15
    (modem_change[M_CALL] && change_enable[0])
      |=> tx_empty_or_line_change_n_oe)
    else $error("enabled call change not requested");

  empty_hold_a: assert property ( // RULE12
    (tx_empty_latched && rd_stat1 && !wr_thr && !tx_shift_done)
      |=> tx_empty_or_line_change_n_oe [*2])
    else $error("status read released while tx empty");

  stat2_read_a: assert property ( // RULE15 RULE16 RULE17 RULE23
    rd_start && register_select == ADDR_STAT2
      |=> host_data_bus_out[4:0] == ~$past(modem_level[4:0]))
    else $error("status two input bits wrong");

  sync_write_a: assert property ( // RULE19
    wr_start && register_select == ADDR_SYNC_CHAR_SECOND
      |=> sync_char_second == $past(host_data_bus_in))
    else $error("sync character not stored");

  rx_keep_a: assert property ( // RULE21
    (rx_char_flag && !rd_rhr) |=> $stable(rx_holding_reg))
    else $error("unread character overwritten");

  rx_take_c: cover property (rx_take ##[1:20] rd_rhr);
  change_clr_c: cover property (change_latched && rd_stat1);
  tx_load_c: cover property (wr_thr ##[1:50] tx_char_taken);

endmodule

//--- rtl/uhp_pkg.sv
// constants for the usart host port and status block
//
// Behaviour
// RULE1: selected access follows direction and select lines
// RULE2: deselected device floats all data lines
// RULE3: low direction reads, high writes, when selected
// RULE4: data bus is 8 bits, bit 0 least
// RULE5: three select lines pick the register
// RULE6: receive-ready low while a character waits
// RULE7: receive-ready released by read or receiver off
// RULE8: transmit-ready low while holding register free
// RULE9: processor trusts transmit-ready only when enabled
// RULE10: empty/change low on tx empty, mode/ready change
// RULE11: enabled extra modem inputs also raise change
// RULE12: status-one read releases unless tx empty
// RULE13: three request outputs are open drain
// RULE14: master reset clears everything asynchronously
// RULE15: status-two bit 0 inverted call, enable bit 5
// RULE16: status-two bit 1 inverted test, enable bit 6
// RULE17: status-two bit 2 inverted quality, enable bit 7
// RULE18: serial receive high is mark, low space
// RULE19: three written sync and escape character registers
// RULE20: sixteen divided rates or external clock
// RULE21: received character held until processor reads
// RULE22: modem inputs synchronised, each change flagged once
// RULE23: standby and rate inputs in bits 3,4, enable 7
package uhp_pkg;

  // ------------------------------------------------------------
  // register select codes
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_HOLD  = 3'h0;
  localparam logic [2:0] ADDR_STAT1 = 3'h1;
  localparam logic [2:0] ADDR_MODE1 = 3'h2;
  localparam logic [2:0] ADDR_MODE2 = 3'h3;
  localparam logic [2:0] ADDR_CMD   = 3'h4;
  localparam logic [2:0] ADDR_STAT2 = 3'h5;
  localparam logic [2:0] ADDR_SYNC_CHAR_SECOND  = 3'h6;
  localparam logic [2:0] ADDR_ESC   = 3'h7;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int S1_TX_FREE   = 0;
  localparam int S1_RX_CHAR   = 1;
  localparam int S1_EMPTY_CHG = 2;
  localparam int S1_LINE_RDY  = 6;
  localparam int S1_DATA_MODE = 7;
  localparam int S2_EN_LO     = 5;
  localparam int CMD_TX_EN    = 0;
  localparam int CMD_RX_EN    = 2;
  localparam int MODE2_INT    = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

  // modem input order inside the synchroniser vector
  localparam int MODEM_N  = 7;
  localparam int M_CALL   = 0;
  localparam int M_TEST   = 1;
  localparam int M_QUAL   = 2;
  localparam int M_STBY   = 3;
  localparam int M_RATE   = 4;
  localparam int M_READY  = 5;
  localparam int M_DMODE  = 6;

  // ------------------------------------------------------------
  // rate divisors, entry 0 in the low bits
  // ------------------------------------------------------------
  localparam int DIV_W = 13;
  localparam logic [16*DIV_W-1:0] BAUD_TABLE = {
    13'h0010, 13'h0020, 13'h0040, 13'h0080,
    13'h009A, 13'h00AB, 13'h0100, 13'h0124,
    13'h0200, 13'h0400, 13'h0600, 13'h0800,
    13'h08EC, 13'h0AE9, 13'h1000, 13'h1800};

endpackage
